/* File: src/synth_divider_lock_detect.sv */
/*
 * Digital counting, sampling sequence and lock detection of the synchronizer.
 * Assumes prescaler input, reference oscillators and the external reference
 * sense come from pins asynchronous to clk; all are synchronised here.
 */
`timescale 1ns/1ps

// **************************************************
// Decade counter: divide-by-five then divide-by-two
// **************************************************
module decade_stage
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic load,
	input wire logic [3:0] preset,
	output logic [3:0] digit,
	output logic carry,
	output logic quinary_wrap
);
	logic [2:0] quin_ff;
	logic bin_ff;
	// Digit value: five times binary half plus quinary count
	assign digit = {bin_ff, 3'h0} + {bin_ff, 2'h0} - {bin_ff, 3'h0} + {1'b0, quin_ff} +
		(bin_ff ? 4'h5 : 4'h0) - {bin_ff, 2'h0};
	assign quinary_wrap = en && (quin_ff == synth_pkg::QUINARY_LAST);
	assign carry = quinary_wrap && bin_ff;

	// Divide-by-five feeds divide-by-two
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			quin_ff <= 3'h0;
			bin_ff <= 1'b0;
		end
		else if (load)
		begin
			quin_ff <= (preset >= 4'h5) ? 3'(preset - 4'h5) : preset[2:0];
			bin_ff <= (preset >= 4'h5);
		end
		else if (en)
		begin
			quin_ff <= quinary_wrap ? 3'h0 : quin_ff + 3'h1;
			if (quinary_wrap)
				bin_ff <= ~bin_ff;
		end
	end
endmodule

// **************************************************
// Programmable divider with reload sequence
// **************************************************
module prog_divider #(
	parameter int DECADES = 5
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_en,
	input wire logic [4*DECADES-1:0] preset,
	output logic sample_pulse
);
	logic [DECADES:0] chain;
	logic [DECADES-1:0] upper_nine;
	logic [3:0] dig [DECADES];
	logic full_seen_ff;
	logic [2:0] extra_ff;
	logic reload_ff;
	logic upper_full;
	logic full_now;

	assign chain[0] = in_en && !full_seen_ff;
	// One counter per decade, chained by carry
	genvar g;
	generate
		for (g = 0; g < DECADES; g++)
		begin : g_dec
			decade_stage u_dec (
				.clk(clk),
				.rst_n(rst_n),
				.en(chain[g]),
				.load(reload_ff),
				.preset(preset[4*g +: 4]),
				.digit(dig[g]),
				.carry(chain[g+1]),
				.quinary_wrap()
			);
			assign upper_nine[g] = (g == 0) ? 1'b1 : (dig[g] == synth_pkg::DIGIT_FULL);
		end
	endgenerate

	// Full: upper decades nine, lowest five
	assign upper_full = &upper_nine;
	assign full_now = upper_full && (dig[0] == synth_pkg::LOW_FULL);

	// Count four more clocks then reload preset X; ratio is Z-X
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			full_seen_ff <= 1'b0;
			extra_ff <= 3'h0;
			reload_ff <= 1'b1;
			sample_pulse <= 1'b0;
		end
		else
		begin
			reload_ff <= 1'b0;
			sample_pulse <= 1'b0;
			if (!full_seen_ff && full_now && !reload_ff)
			begin
				full_seen_ff <= 1'b1;
				extra_ff <= 3'h0;
				sample_pulse <= 1'b1;
			end
			else if (full_seen_ff && in_en)
			begin
				extra_ff <= extra_ff + 3'h1;
				if (extra_ff == synth_pkg::EXTRA_CLOCKS - 3'h1)
				begin
					full_seen_ff <= 1'b0;
					reload_ff <= 1'b1;
				end
			end
		end
	end
endmodule

// **************************************************
// Fixed reference chain with narrow output pulse
// **************************************************
module ref_chain
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_en,
	output logic first_quinary,
	output logic pulse_en
);
	logic [synth_pkg::REF_DECADES:0] rc;
	// Four cascaded decades
	genvar g;
	generate
		for (g = 0; g < synth_pkg::REF_DECADES; g++)
		begin : g_ref
			if (g == 0)
			begin : g_first
				decade_stage u_dec (
					.clk(clk),
					.rst_n(rst_n),
					.en(rc[g]),
					.load(1'b0),
					.preset(synth_pkg::DIGIT_RESET),
					.digit(),
					.carry(rc[g+1]),
					.quinary_wrap(first_quinary)
				);
			end
			else
			begin : g_rest
				decade_stage u_dec (
					.clk(clk),
					.rst_n(rst_n),
					.en(rc[g]),
					.load(1'b0),
					.preset(synth_pkg::DIGIT_RESET),
					.digit(),
					.carry(rc[g+1]),
					.quinary_wrap()
				);
			end
		end
	endgenerate
	assign rc[0] = in_en;
	assign pulse_en = rc[synth_pkg::REF_DECADES];
endmodule

// **************************************************
// Sampling driver: isolation, delay, transfer one-shots
// **************************************************
module sampling_driver
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig,
	output logic isolate,
	output logic transfer,
	output logic clear_pulse
);
	logic [15:0] iso_ff;
	logic [15:0] dly_ff;
	logic [15:0] xfr_ff;
	logic [15:0] clr_ff;
	logic dly_end;
	assign dly_end = (dly_ff == 16'h0001);
	assign isolate = (iso_ff != 16'h0000);
	assign transfer = (xfr_ff != 16'h0000);
	assign clear_pulse = (clr_ff != 16'h0000);

	// Down-counter one-shots; transfer starts when delay ends
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			iso_ff <= 16'h0000;
			dly_ff <= 16'h0000;
			xfr_ff <= 16'h0000;
			clr_ff <= 16'h0000;
		end
		else
		begin
			iso_ff <= trig ? 16'(synth_pkg::ISO_CYC) : (isolate ? iso_ff - 16'h0001 : iso_ff);
			dly_ff <= trig ? 16'(synth_pkg::DLY_CYC) : (dly_ff != 16'h0000 ? dly_ff - 16'h0001 : dly_ff);
			xfr_ff <= dly_end ? 16'(synth_pkg::XFER_CYC) : (transfer ? xfr_ff - 16'h0001 : xfr_ff);
			clr_ff <= trig ? 16'(synth_pkg::CLR_CYC) : (clear_pulse ? clr_ff - 16'h0001 : clr_ff);
		end
	end
endmodule

// **************************************************
// Top: dividers, reference chains, drivers, lock detect
// **************************************************
module synth_divider_lock_detect #(
	parameter int STRETCH_CYCLES = synth_pkg::STRETCH_CYC
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic gen_in,
	input wire logic tuned_crystal_osc,
	input wire logic standard_crystal_osc,
	input wire logic external_reference_select,
	input wire logic ext_ref_present,
	input wire logic [4*synth_pkg::FAST_DECADES-1:0] fast_digits,
	input wire logic [4*synth_pkg::SLOW_DECADES-1:0] slow_digits,
	output logic std_1mhz_out,
	output logic fast_ramp_discharge,
	output logic slow_ramp_discharge,
	output logic fast_track_on,
	output logic fast_transfer_on,
	output logic slow_track_on,
	output logic slow_transfer_on,
	output logic unlocked_indicator
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [2:0] gen_s_ff, tun_s_ff, std_s_ff;
	logic [1:0] ext_s_ff;
	logic gen_edge, tun_edge, std_edge;
	logic [synth_pkg::PRE_BITS-1:0] pre_ff;
	logic pre_en;
	logic fast_pulse, slow_pulse;
	logic std_quin, std_pulse, tun_quin, tun_pulse;
	logic f_iso, f_xfr, f_clr, s_iso, s_xfr, s_clr;
	logic square_ff;
	logic [1:0] div4_ff;
	logic div4_hold;
	logic trigger;
	logic [31:0] stretch_ff;
	logic [3:0] std_w_ff, tun_w_ff;
	logic mhz_ff;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// Pin synchronisers; third stage only for edge detect
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gen_s_ff <= 3'h0;
			tun_s_ff <= 3'h0;
			std_s_ff <= 3'h0;
			ext_s_ff <= 2'h0;
		end
		else
		begin
			gen_s_ff <= {gen_s_ff[1:0], gen_in};
			tun_s_ff <= {tun_s_ff[1:0], tuned_crystal_osc};
			std_s_ff <= {std_s_ff[1:0], standard_crystal_osc};
			ext_s_ff <= {ext_s_ff[0], ext_ref_present};
		end
	end
	assign gen_edge = gen_s_ff[1] && !gen_s_ff[2];
	assign tun_edge = tun_s_ff[1] && !tun_s_ff[2];
	assign std_edge = std_s_ff[1] && !std_s_ff[2];

	// Prescale generator edges by twenty
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_ff <= '0;
		else if (gen_edge)
			pre_ff <= pre_en ? '0 : pre_ff + 1'b1;
	end
	assign pre_en = gen_edge && (pre_ff == synth_pkg::PRE_BITS'(synth_pkg::PRESCALE_DIV - 1));

	// Fast and slow programmable dividers; identical structure
	prog_divider #(.DECADES(synth_pkg::FAST_DECADES)) fast_prog_divider (
		.clk(clk),
		.rst_n(rst_n),
		.in_en(pre_en),
		.preset(fast_digits),
		.sample_pulse(fast_pulse)
	);
	prog_divider #(.DECADES(synth_pkg::SLOW_DECADES)) slow_prog_divider (
		.clk(clk),
		.rst_n(rst_n),
		.in_en(pre_en),
		.preset(slow_digits),
		.sample_pulse(slow_pulse)
	);

	// Reference chains
	ref_chain std_ref_chain (
		.clk(clk),
		.rst_n(rst_n),
		.in_en(std_edge),
		.first_quinary(std_quin),
		.pulse_en(std_pulse)
	);
	ref_chain tuned_ref_chain (
		.clk(clk),
		.rst_n(rst_n),
		.in_en(tun_edge),
		.first_quinary(tun_quin),
		.pulse_en(tun_pulse)
	);

	// Sampling drivers
	sampling_driver fast_sampling_driver (
		.clk(clk),
		.rst_n(rst_n),
		.trig(fast_pulse),
		.isolate(f_iso),
		.transfer(f_xfr),
		.clear_pulse(f_clr)
	);
	sampling_driver slow_sampling_driver (
		.clk(clk),
		.rst_n(rst_n),
		.trig(slow_pulse),
		.isolate(s_iso),
		.transfer(s_xfr),
		.clear_pulse(s_clr)
	);

	// Lock detect trigger: pulse while square low, or div4 hold
	assign div4_hold = (div4_ff == 2'b11);
	assign trigger = fast_pulse && (!square_ff || div4_hold);

	// Square wave toggled by 1 kHz, cleared after divider pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			square_ff <= 1'b0;
		else if (f_clr)
			square_ff <= 1'b0;
		else if (tun_pulse)
			square_ff <= ~square_ff;
	end

	// Divide-by-four of reference pulses, stops at three
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div4_ff <= 2'b00;
		else if (f_clr)
			div4_ff <= 2'b00;
		else if (tun_pulse && !div4_hold)
			div4_ff <= div4_ff + 2'b01;
	end

	// Stretch indicator; held on when external missing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stretch_ff <= 32'h00000000;
		else if (trigger)
			stretch_ff <= 32'(STRETCH_CYCLES);
		else if (stretch_ff != 32'h00000000)
			stretch_ff <= stretch_ff - 32'h00000001;
	end

	// Registered outputs: ramps, switches, standard, indicator
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			std_w_ff <= 4'h0;
			tun_w_ff <= 4'h0;
			mhz_ff <= 1'b0;
			std_1mhz_out <= 1'b0;
			fast_ramp_discharge <= 1'b0;
			slow_ramp_discharge <= 1'b0;
			fast_track_on <= 1'b1;
			fast_transfer_on <= 1'b0;
			slow_track_on <= 1'b1;
			slow_transfer_on <= 1'b0;
			unlocked_indicator <= 1'b1;
		end
		else
		begin
			std_w_ff <= std_pulse ? synth_pkg::REF_PULSE_CYC : (std_w_ff != 4'h0 ? std_w_ff - 4'h1 : 4'h0);
			tun_w_ff <= tun_pulse ? synth_pkg::REF_PULSE_CYC : (tun_w_ff != 4'h0 ? tun_w_ff - 4'h1 : 4'h0);
			mhz_ff <= std_quin; // One high cycle per divide-by-five wrap, so 1 MHz
			std_1mhz_out <= mhz_ff;
			slow_ramp_discharge <= std_pulse || (std_w_ff != 4'h0);
			fast_ramp_discharge <= tun_pulse || (tun_w_ff != 4'h0);
			fast_track_on <= !f_iso;
			fast_transfer_on <= f_xfr;
			slow_track_on <= !s_iso;
			slow_transfer_on <= s_xfr;
			unlocked_indicator <= trigger || (stretch_ff != 32'h00000000) ||
				(external_reference_select && !ext_s_ff[1]);
		end
	end
endmodule

/* File: src/synth_pkg.sv */
/*
 * Constants for the synchronizer counting, timing and lock detect logic.
 * Assumes a single 100 MHz system clock; all rates below are enables.
 */
package synth_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int ISO_NS = 2000;
	localparam int DLY_NS = 200;
	localparam int XFER_NS = 1000;
	localparam int CLR_NS = 100;
	localparam int ISO_CYC = (ISO_NS * CLK_MHZ + 999) / 1000;
	localparam int DLY_CYC = (DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int XFER_CYC = (XFER_NS * CLK_MHZ + 999) / 1000;
	localparam int CLR_CYC = (CLR_NS * CLK_MHZ + 999) / 1000;
	// Unlocked_indicator stretch, 100 ms
	localparam int STRETCH_MS = 100;
	localparam int STRETCH_CYC = STRETCH_MS * CLK_MHZ * 1000;
	// Divider structure
	localparam int FAST_DECADES = 5;
	localparam int SLOW_DECADES = 7;
	localparam int REF_DECADES = 4;
	localparam int PRESCALE_DIV = 20;
	localparam int PRE_BITS = 5;
	localparam logic [3:0] DIGIT_FULL = 4'h9;
	localparam logic [3:0] LOW_FULL = 4'h5;
	localparam logic [2:0] EXTRA_CLOCKS = 3'h4;
	localparam logic [2:0] QUINARY_LAST = 3'h4;
	localparam logic [3:0] DIGIT_RESET = 4'h0;
	// Reference pulse extension in system clocks; the pulse is one clock wider
	localparam logic [3:0] REF_PULSE_CYC = 4'h2;
endpackage

/* File: tb/osc_source.sv */
/* Signal generator output and crystal oscillators, behavioural.
 * Each running source toggles just after every rising clock edge; stopped ones hold. */
`timescale 1ns/1ps
// ****************
// Source model
// ****************
module osc_source
(
	input wire logic clk,
	input wire logic run_gen,
	input wire logic run_tuned,
	input wire logic run_std,
	output logic gen_in,
	output logic tuned_crystal_osc,
	output logic standard_crystal_osc
);
	initial
	begin
		gen_in = 1'b0;
		tuned_crystal_osc = 1'b0;
		standard_crystal_osc = 1'b0;
	end
	// One source period spans two clocks
	always @(posedge clk)
	begin
		if (run_gen)
			gen_in <= #1 ~gen_in;
		if (run_tuned)
			tuned_crystal_osc <= #1 ~tuned_crystal_osc;
		if (run_std)
			standard_crystal_osc <= #1 ~standard_crystal_osc;
	end
endmodule

/* File: tb/synth_checker_props.sv */
/* Checker for sampling driver and lock indicator timing.
 * Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
// ****************
// Timing checker
// ****************
module synth_checker #(
	parameter int STRETCH_CYCLES = 50
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic external_reference_select,
	input wire logic ext_ref_present,
	input wire logic fast_ramp_discharge,
	input wire logic fast_track_on,
	input wire logic fast_transfer_on,
	input wire logic slow_track_on,
	input wire logic slow_transfer_on,
	input wire logic unlocked_indicator
);
	localparam int DL = synth_pkg::DLY_CYC;
	localparam int ISO = synth_pkg::ISO_CYC;
	localparam int XF = synth_pkg::XFER_CYC;
	logic [31:0] low_cnt_ff = 32'h0;
	logic [31:0] xfer_cnt_ff = 32'h0;
	logic [31:0] lit_cnt_ff = 32'h0;
	logic armed_ff = 1'b0;
	// Run lengths of isolation, transfer and indicator
	always_ff @(posedge clk)
	begin
		low_cnt_ff <= fast_track_on ? 32'h0 : low_cnt_ff + 32'h1;
		xfer_cnt_ff <= fast_transfer_on ? xfer_cnt_ff + 32'h1 : 32'h0;
		lit_cnt_ff <= unlocked_indicator ? lit_cnt_ff + 32'h1 : 32'h0;
		// Ignore the lit spell that reset leaves behind
		armed_ff <= armed_ff || (reset_n && !unlocked_indicator);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_iso_width: assert property ($rose(fast_track_on) |-> low_cnt_ff == 32'(ISO))
		else $error("isolation width wrong");
	a_fast_xfer_delay: assert property ($fell(fast_track_on) |-> ##DL $rose(fast_transfer_on))
		else $error("fast transfer delay wrong");
	a_slow_xfer_delay: assert property ($fell(slow_track_on) |-> ##DL $rose(slow_transfer_on))
		else $error("slow transfer delay wrong");
	a_xfer_width: assert property ($fell(fast_transfer_on) |-> xfer_cnt_ff == 32'(XF))
		else $error("transfer width wrong");
	a_fast_isolated: assert property (fast_transfer_on |-> !fast_track_on)
		else $error("fast transfer while tracking");
	a_slow_isolated: assert property (slow_track_on |-> !slow_transfer_on)
		else $error("slow transfer while tracking");
	a_ext_hold: assert property ((external_reference_select && !ext_ref_present)[*6]
		|-> unlocked_indicator)
		else $error("indicator off without external input");
	a_lit_stretch: assert property (armed_ff && $fell(unlocked_indicator)
		|-> lit_cnt_ff >= 32'(STRETCH_CYCLES))
		else $error("indicator not stretched");
	a_disch_narrow: assert property ($rose(fast_ramp_discharge)
		|-> ##[1:6] !fast_ramp_discharge)
		else $error("discharge pulse too wide");
endmodule

bind synth_divider_lock_detect synth_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
	.clk,
	.reset_n,
	.external_reference_select,
	.ext_ref_present,
	.fast_ramp_discharge,
	.fast_track_on,
	.fast_transfer_on,
	.slow_track_on,
	.slow_transfer_on,
	.unlocked_indicator
);

/* File: tb/synth_divider_lock_detect_tb_top.sv */
/* Testbench for divider ratios, reference chains and lock indicator.
 * Assumes the source model and the bound checker. */
`timescale 1ns/1ps
// ****************
// Testbench
// ****************
module synth_divider_lock_detect_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic run_gen = 1'b0;
	logic run_tuned = 1'b0;
	logic run_std = 1'b0;
	logic ext_sel = 1'b0;
	logic ext_present = 1'b0;
	logic [19:0] fast_digits = 20'h99990;
	logic [27:0] slow_digits = 28'h9999990;
	logic gen_in, tuned_osc, std_osc, std_1mhz_out, fast_disch, slow_disch;
	logic fast_track_on, fast_transfer_on, slow_track_on, slow_transfer_on, unlocked_indicator;
	int n_fail = 0;
	int cmp_count = 0;
	int gen_cnt = 0;
	int tuned_cnt = 0;
	int std_cnt = 0;

	always #5 clk = ~clk;
	always @(posedge gen_in) gen_cnt++;
	always @(posedge tuned_osc) tuned_cnt++;
	always @(posedge std_osc) std_cnt++;

	osc_source u_src (.clk(clk), .run_gen(run_gen), .run_tuned(run_tuned),
		.run_std(run_std), .gen_in(gen_in), .tuned_crystal_osc(tuned_osc),
		.standard_crystal_osc(std_osc));

	synth_divider_lock_detect #(.STRETCH_CYCLES(50)) u_dut (.clk(clk), .reset_n(reset_n),
		.gen_in(gen_in), .tuned_crystal_osc(tuned_osc), .standard_crystal_osc(std_osc),
		.external_reference_select(ext_sel), .ext_ref_present(ext_present),
		.fast_digits(fast_digits), .slow_digits(slow_digits), .std_1mhz_out(std_1mhz_out),
		.fast_ramp_discharge(fast_disch), .slow_ramp_discharge(slow_disch),
		.fast_track_on(fast_track_on), .fast_transfer_on(fast_transfer_on),
		.slow_track_on(slow_track_on), .slow_transfer_on(slow_transfer_on),
		.unlocked_indicator(unlocked_indicator));

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Output watched by each selector, and the source edges counted for it
	function automatic logic pick(input int sel);
		case (sel)
			0: return fast_track_on;
			1: return slow_track_on;
			2: return std_1mhz_out;
			3: return fast_disch;
			default: return slow_disch;
		endcase
	endfunction

	function automatic int cnt_of(input int sel);
		return (sel < 2) ? gen_cnt : ((sel == 3) ? tuned_cnt : std_cnt);
	endfunction

	// Waits, bounded, until the watched output moves to lvl
	task automatic next_edge(input int sel, input logic lvl);
		logic p;
		logic c;
		p = pick(sel);
		for (int i = 0; i < 30000; i++)
		begin
			step(1);
			c = pick(sel);
			if (p === ~lvl && c === lvl)
				return;
			p = c;
		end
		n_fail++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, p, lvl);
	endtask

	task automatic gap(input int sel, input logic lvl, output int d);
		int c0;
		next_edge(sel, lvl);
		c0 = cnt_of(sel);
		next_edge(sel, lvl);
		d = cnt_of(sel) - c0;
	endtask

	task automatic load(input int sel, input logic [7:0] low);
		if (sel == 0)
			fast_digits = {12'h999, low};
		else
			slow_digits = {20'h99999, low};
	endtask

	// Indicator with no pulses, external reference handling, unlocked pulses
	task automatic t_lock();
		step(100);
		chk(32'(unlocked_indicator), 32'h0);
		ext_sel = 1'b1;
		step(60);
		chk(32'(unlocked_indicator), 32'h1);
		ext_present = 1'b1;
		step(100);
		chk(32'(unlocked_indicator), 32'h0);
		ext_sel = 1'b0;
		ext_present = 1'b0;
		run_gen = 1'b1;
		next_edge(0, 1'b0);
		step(10);
		chk(32'(unlocked_indicator), 32'h1);
	endtask

	// Spacing of sampling pulses in generator edges for three presets
	task automatic t_divider(input int sel);
		int d0;
		int d1;
		int d2;
		load(sel, 8'h90);
		next_edge(sel, 1'b0);
		gap(sel, 1'b0, d0);
		load(sel, 8'h89);
		next_edge(sel, 1'b0);
		gap(sel, 1'b0, d1);
		load(sel, 8'h80);
		next_edge(sel, 1'b0);
		gap(sel, 1'b0, d2);
		chk(32'(d0 % 20), 32'h0);
		chk(32'(d1 - d0), 32'h14);
		chk(32'(d2 - d0), 32'hC8);
	endtask

	// Standard output and both reference chain periods
	task automatic t_ref();
		int d;
		int da;
		int db;
		run_tuned = 1'b1;
		run_std = 1'b1;
		gap(2, 1'b1, d);
		chk(32'(d), 32'h5);
		fork
			gap(3, 1'b1, da);
			gap(4, 1'b1, db);
		join
		chk(32'(da), 32'h2710);
		chk(32'(db), 32'h2710);
	endtask

	initial
	begin
		step(4);
		reset_n = 1'b1;
		step(4);
		t_lock();
		t_divider(0);
		t_divider(1);
		run_gen = 1'b0;
		t_ref();
		final_report();
	end

	// Watchdog
	initial
	begin
		repeat (95000) @(posedge clk);
		n_fail++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1, 0);
		final_report();
	end
endmodule
